// ---- hw/irq_priority_controller.sv ----
`timescale 1ns/100ps
`include "irq_prio_cfg.svh"
// Functional notes
// - reserved bits read as zero and ignore writes.
// - debug-unit fields map 00 off, 01 to level 1, 10 to level 2, 11 to level 3.
// - other fields map 00 off, 01 to level 0, 10 to level 1, 11 to level 2.
// - every field resets to 00 so all sources start disabled.
// - register 0 holds breakpoint 0 at 13:12 and step counter at 11:10, rest reserved.
// - register 1 holds rx full at 5:4, tx empty at 3:2, trace buffer at 1:0.
// - register 2 holds flash buffers empty 15:14, command done 13:12, fault 11:10.
// - register 2 holds pll loss 9:8, low supply 7:6, pins b 3:2 and a 1:0, 5:4 reserved.
// - register 3 holds ports d, e, f at 15:14, 13:12, 11:10.
// - register 3 holds message buffer 9:8, wake 7:6, fault 5:4, bits 1:0 reserved.
// - within one level the lowest numbered active source wins.
// - only sources enabled before low-power entry may wake the core.
module irq_priority_controller #(
    parameter int NSRC = `NUM_SOURCES,
    parameter int NDBG = `NUM_DEBUG_SOURCES
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic clk_en,
    // register port
    input wire irq_prio_pkg::reg_addr_t reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire irq_prio_pkg::reg_word_t reg_wdata,
    output irq_prio_pkg::reg_word_t reg_rdata_r,
    // interrupt sources
    input wire logic [NSRC-1:0] src_req,
    // arbitration results
    output logic [`NUM_LEVELS-1:0] level_hit_r,
    output logic [`NUM_LEVELS-1:0][4:0] level_src_r,
    output logic irq_valid_r,
    output irq_prio_pkg::prio_level_t irq_level_r,
    output irq_prio_pkg::src_index_t irq_src_r,
    // low-power wake-up
    input wire logic low_power,
    output logic wake_req_r
);
    import irq_prio_pkg::*;

    // returns {enabled, level}
    function automatic logic [2:0] decode_level(input prio_field_t f, input logic dbg);
        logic [2:0] r;
        r = 3'h0;
        if (f != 2'h0) begin
            if (dbg) begin
                r = {1'b1, f};
            end else begin
                r = {1'b1, 2'(f - 2'h1)};
            end
        end
        return r;
    endfunction : decode_level

    reg_word_t debug_event_prio_cfg_r, debug_event_prio_cfg_nxt;
    reg_word_t debug_comm_prio_cfg_r, debug_comm_prio_cfg_nxt;
    reg_word_t system_prio_cfg_r, system_prio_cfg_nxt;
    reg_word_t port_msg_prio_cfg_r, port_msg_prio_cfg_nxt;
    reg_word_t reg_rdata_nxt;

    // register writes and reads
    always_comb begin
        debug_event_prio_cfg_nxt = debug_event_prio_cfg_r;
        debug_comm_prio_cfg_nxt = debug_comm_prio_cfg_r;
        system_prio_cfg_nxt = system_prio_cfg_r;
        port_msg_prio_cfg_nxt = port_msg_prio_cfg_r;
        reg_rdata_nxt = 16'h0000;
        if (reg_wr) begin
            unique case (reg_addr)
                `OFS_DEBUG_EVENT_PRIO: debug_event_prio_cfg_nxt =
                    reg_wdata & `MASK_DEBUG_EVENT_PRIO;
                `OFS_DEBUG_COMM_PRIO: debug_comm_prio_cfg_nxt =
                    reg_wdata & `MASK_DEBUG_COMM_PRIO;
                `OFS_SYSTEM_PRIO: system_prio_cfg_nxt =
                    reg_wdata & `MASK_SYSTEM_PRIO;
                `OFS_PORT_MSG_PRIO: port_msg_prio_cfg_nxt =
                    reg_wdata & `MASK_PORT_MSG_PRIO;
                default: begin
                end
            endcase
        end
        if (reg_rd) begin
            unique case (reg_addr)
                `OFS_DEBUG_EVENT_PRIO: reg_rdata_nxt = debug_event_prio_cfg_r;
                `OFS_DEBUG_COMM_PRIO: reg_rdata_nxt = debug_comm_prio_cfg_r;
                `OFS_SYSTEM_PRIO: reg_rdata_nxt = system_prio_cfg_r;
                `OFS_PORT_MSG_PRIO: reg_rdata_nxt = port_msg_prio_cfg_r;
                default: reg_rdata_nxt = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            debug_event_prio_cfg_r <= `RST_PRIO_CFG;
            debug_comm_prio_cfg_r <= `RST_PRIO_CFG;
            system_prio_cfg_r <= `RST_PRIO_CFG;
            port_msg_prio_cfg_r <= `RST_PRIO_CFG;
            reg_rdata_r <= 16'h0000;
        end else if (clk_en) begin
            debug_event_prio_cfg_r <= debug_event_prio_cfg_nxt;
            debug_comm_prio_cfg_r <= debug_comm_prio_cfg_nxt;
            system_prio_cfg_r <= system_prio_cfg_nxt;
            port_msg_prio_cfg_r <= port_msg_prio_cfg_nxt;
            reg_rdata_r <= reg_rdata_nxt;
        end
    end

    // per-source fields, index is the source number
    prio_field_t src_field [NSRC];
    always_comb begin
        for (int i = 0; i < NSRC; i++) begin
            src_field[i] = 2'h0;
        end
        src_field[0] = debug_event_prio_cfg_r[`POS_BREAKPOINT0_LEVEL +: 2];
        src_field[1] = debug_event_prio_cfg_r[`POS_STEP_COUNTER_LEVEL +: 2];
        src_field[2] = debug_comm_prio_cfg_r[`POS_DEBUG_RX_FULL_LEVEL +: 2];
        src_field[3] = debug_comm_prio_cfg_r[`POS_DEBUG_TX_EMPTY_LEVEL +: 2];
        src_field[4] = debug_comm_prio_cfg_r[`POS_TRACE_BUFFER_LEVEL +: 2];
        src_field[5] = system_prio_cfg_r[`POS_FLASH_BUFFERS_EMPTY_LEVEL +: 2];
        src_field[6] = system_prio_cfg_r[`POS_FLASH_CMD_DONE_LEVEL +: 2];
        src_field[7] = system_prio_cfg_r[`POS_FLASH_FAULT_LEVEL +: 2];
        src_field[8] = system_prio_cfg_r[`POS_PLL_PHASE_LOSS_LEVEL +: 2];
        src_field[9] = system_prio_cfg_r[`POS_LOW_SUPPLY_LEVEL +: 2];
        src_field[10] = system_prio_cfg_r[`POS_EXT_PIN_B_LEVEL +: 2];
        src_field[11] = system_prio_cfg_r[`POS_EXT_PIN_A_LEVEL +: 2];
        src_field[12] = port_msg_prio_cfg_r[`POS_PORT_D_LEVEL +: 2];
        src_field[13] = port_msg_prio_cfg_r[`POS_PORT_E_LEVEL +: 2];
        src_field[14] = port_msg_prio_cfg_r[`POS_PORT_F_LEVEL +: 2];
        src_field[15] = port_msg_prio_cfg_r[`POS_MSG_BUFFER_LEVEL +: 2];
        src_field[16] = port_msg_prio_cfg_r[`POS_MSG_WAKE_LEVEL +: 2];
        src_field[17] = port_msg_prio_cfg_r[`POS_MSG_FAULT_LEVEL +: 2];
        src_field[18] = port_msg_prio_cfg_r[`POS_MSG_BUSOFF_LEVEL +: 2];
    end

    // enable and level per source, then per-level request vectors
    logic [NSRC-1:0] src_en;
    logic [`NUM_LEVELS-1:0][NSRC-1:0] lvl_req;
    logic [`NUM_LEVELS-1:0] lvl_hit;
    logic [`NUM_LEVELS-1:0][4:0] lvl_idx;

    always_comb begin
        logic [2:0] d;
        d = 3'h0;
        lvl_req = '0;
        for (int i = 0; i < NSRC; i++) begin
            d = decode_level(src_field[i], i < NDBG);
            src_en[i] = d[2];
            lvl_req[d[1:0]][i] = d[2] & src_req[i];
        end
    end

    genvar g;
    generate
        for (g = 0; g < `NUM_LEVELS; g++) begin : g_level
            prio_encoder #(
                .N(NSRC),
                .IW(5)
            ) u_enc (
                .req(lvl_req[g]),
                .hit(lvl_hit[g]),
                .index(lvl_idx[g])
            );
        end
    endgenerate

    // arbitration result: highest active level, its lowest source number
    logic irq_valid_nxt;
    prio_level_t irq_level_nxt;
    src_index_t irq_src_nxt;
    always_comb begin
        irq_valid_nxt = 1'b0;
        irq_level_nxt = 2'h0;
        irq_src_nxt = 5'h00;
        for (int l = 0; l < `NUM_LEVELS; l++) begin
            if (lvl_hit[l]) begin
                irq_valid_nxt = 1'b1;
                irq_level_nxt = 2'(l);
                irq_src_nxt = lvl_idx[l];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            level_hit_r <= '0;
            level_src_r <= '0;
            irq_valid_r <= 1'b0;
            irq_level_r <= 2'h0;
            irq_src_r <= 5'h00;
        end else if (clk_en) begin
            level_hit_r <= lvl_hit;
            level_src_r <= lvl_idx;
            irq_valid_r <= irq_valid_nxt;
            irq_level_r <= irq_level_nxt;
            irq_src_r <= irq_src_nxt;
        end
    end

    // wake-up: enable mask is frozen on entry to low power
    logic lp_r, lp_nxt;
    logic [NSRC-1:0] wake_mask_r, wake_mask_nxt;
    logic wake_req_nxt;
    always_comb begin
        lp_nxt = low_power;
        wake_mask_nxt = wake_mask_r;
        if (low_power && !lp_r) begin
            wake_mask_nxt = src_en;
        end
        wake_req_nxt = lp_r & low_power & (|(src_req & wake_mask_r));
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            lp_r <= 1'b0;
            wake_mask_r <= '0;
            wake_req_r <= 1'b0;
        end else if (clk_en) begin
            lp_r <= lp_nxt;
            wake_mask_r <= wake_mask_nxt;
            wake_req_r <= wake_req_nxt;
        end
    end
endmodule : irq_priority_controller

// ---- hw/prio_encoder.sv ----
`timescale 1ns/100ps
module prio_encoder #(
    parameter int N = 19,
    parameter int IW = 5
) (
    // requests, bit 0 ranks highest
    input wire logic [N-1:0] req,
    // result
    output logic hit,
    output logic [IW-1:0] index
);
    always_comb begin
        hit = 1'b0;
        index = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (req[i]) begin
                hit = 1'b1;
                index = IW'(i);
            end
        end
    end
endmodule : prio_encoder

// ---- inc/irq_prio_cfg.svh ----
`ifndef IRQ_PRIO_CFG_SVH
`define IRQ_PRIO_CFG_SVH

// register word offsets
`define OFS_DEBUG_EVENT_PRIO 5'h00
`define OFS_DEBUG_COMM_PRIO 5'h01
`define OFS_SYSTEM_PRIO 5'h02
`define OFS_PORT_MSG_PRIO 5'h03

// reset values
`define RST_PRIO_CFG 16'h0000

// writable bit masks, reserved bits stay zero
`define MASK_DEBUG_EVENT_PRIO 16'h3C00
`define MASK_DEBUG_COMM_PRIO 16'h003F
`define MASK_SYSTEM_PRIO 16'hFFCF
`define MASK_PORT_MSG_PRIO 16'hFFFC

// field low-bit positions
`define POS_BREAKPOINT0_LEVEL 12
`define POS_STEP_COUNTER_LEVEL 10
`define POS_DEBUG_RX_FULL_LEVEL 4
`define POS_DEBUG_TX_EMPTY_LEVEL 2
`define POS_TRACE_BUFFER_LEVEL 0
`define POS_FLASH_BUFFERS_EMPTY_LEVEL 14
`define POS_FLASH_CMD_DONE_LEVEL 12
`define POS_FLASH_FAULT_LEVEL 10
`define POS_PLL_PHASE_LOSS_LEVEL 8
`define POS_LOW_SUPPLY_LEVEL 6
`define POS_EXT_PIN_B_LEVEL 2
`define POS_EXT_PIN_A_LEVEL 0
`define POS_PORT_D_LEVEL 14
`define POS_PORT_E_LEVEL 12
`define POS_PORT_F_LEVEL 10
`define POS_MSG_BUFFER_LEVEL 8
`define POS_MSG_WAKE_LEVEL 6
`define POS_MSG_FAULT_LEVEL 4
`define POS_MSG_BUSOFF_LEVEL 2

// source count and number of debug-unit sources (numbered first)
`define NUM_SOURCES 19
`define NUM_DEBUG_SOURCES 5
`define NUM_LEVELS 4

`endif

// ---- inc/irq_prio_pkg.sv ----
package irq_prio_pkg;
    typedef logic [1:0] prio_field_t;
    typedef logic [1:0] prio_level_t;
    typedef logic [4:0] src_index_t;
    typedef logic [15:0] reg_word_t;
    typedef logic [4:0] reg_addr_t;
endpackage : irq_prio_pkg

// ---- verif/irq_prio_checker.sv ----
`timescale 1ns/100ps
`include "irq_prio_cfg.svh"
module irq_prio_checker #(
    parameter int NSRC = 19
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic clk_en,
    // register port
    input wire irq_prio_pkg::reg_addr_t reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire irq_prio_pkg::reg_word_t reg_wdata,
    input wire irq_prio_pkg::reg_word_t reg_rdata_r,
    // sources and results
    input wire logic [NSRC-1:0] src_req,
    input wire logic [3:0] level_hit_r,
    input wire logic [3:0][4:0] level_src_r,
    input wire logic irq_valid_r,
    input wire irq_prio_pkg::prio_level_t irq_level_r,
    input wire irq_prio_pkg::src_index_t irq_src_r,
    input wire logic low_power,
    input wire logic wake_req_r
);
    import irq_prio_pkg::*;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    function automatic reg_word_t msk(input reg_addr_t a);
        case (a)
            `OFS_DEBUG_EVENT_PRIO: return `MASK_DEBUG_EVENT_PRIO;
            `OFS_DEBUG_COMM_PRIO: return `MASK_DEBUG_COMM_PRIO;
            `OFS_SYSTEM_PRIO: return `MASK_SYSTEM_PRIO;
            `OFS_PORT_MSG_PRIO: return `MASK_PORT_MSG_PRIO;
            default: return 16'h0000;
        endcase
    endfunction : msk
    a_rdata_idle: assert property (clk_en && !reg_rd |=> reg_rdata_r == 16'h0000)
        else $error("read data not zero when idle");
    a_reserved_zero: assert property (clk_en && reg_rd |=>
        (reg_rdata_r & ~msk($past(reg_addr))) == 16'h0000) else $error("reserved bit set");
    a_write_read_back: assert property (clk_en && reg_wr ##1 clk_en && reg_rd && !reg_wr
        && reg_addr == $past(reg_addr) |=> reg_rdata_r == ($past(reg_wdata, 2)
        & msk($past(reg_addr, 2)))) else $error("write not read back");
    a_valid_any: assert property (irq_valid_r == (level_hit_r != 4'h0))
        else $error("valid differs from level hits");
    a_level_top: assert property (irq_valid_r |-> (level_hit_r >> irq_level_r) == 4'h1)
        else $error("not the highest level");
    a_src_match: assert property (irq_valid_r |-> irq_src_r == level_src_r[irq_level_r])
        else $error("source differs from level winner");
    a_no_request: assert property (clk_en && src_req == '0 |=> !irq_valid_r)
        else $error("valid without request");
    a_wake_needs_lp: assert property (wake_req_r && $past(clk_en) |-> $past(low_power))
        else $error("wake outside low power");
    a_wake_idle: assert property (clk_en && !low_power |=> !wake_req_r)
        else $error("wake while running");
    c_read: cover property (clk_en && reg_rd ##1 reg_rdata_r != 16'h0000);
    c_valid: cover property (irq_valid_r && irq_level_r == 2'h3);
    c_wake: cover property (wake_req_r);
endmodule : irq_prio_checker

// ---- verif/irq_priority_controller_bench.sv ----
`timescale 1ns/100ps
module irq_priority_controller_bench;
    import irq_prio_pkg::*;
    localparam int NSRC = 19;
    logic clk_sys = 1'h0;
    logic reset_n = 1'h0;
    logic clk_en = 1'h1;
    reg_addr_t reg_addr = 5'h00;
    logic reg_wr = 1'h0;
    logic reg_rd = 1'h0;
    reg_word_t reg_wdata = 16'h0000;
    reg_word_t reg_rdata_r;
    logic [NSRC-1:0] raise = '0;
    logic [NSRC-1:0] src_req;
    logic [3:0] level_hit_r;
    logic [3:0][4:0] level_src_r;
    logic irq_valid_r;
    prio_level_t irq_level_r;
    src_index_t irq_src_r;
    logic low_power = 1'h0;
    logic wake_req_r;
    int errors = 0;
    int check_count = 0;
    int cycles = 0;
    reg_word_t mk[6] = '{16'h3C00, 16'h003F, 16'hFFCF, 16'hFFFC, 16'h0000, 16'h0000};
    irq_priority_controller #(.NSRC(NSRC)) dut (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .reg_addr(reg_addr),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_wdata(reg_wdata),
        .reg_rdata_r(reg_rdata_r),
        .src_req(src_req),
        .level_hit_r(level_hit_r),
        .level_src_r(level_src_r),
        .irq_valid_r(irq_valid_r),
        .irq_level_r(irq_level_r),
        .irq_src_r(irq_src_r),
        .low_power(low_power),
        .wake_req_r(wake_req_r)
    );
    irq_src_model #(.NSRC(NSRC)) srcs (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .raise(raise),
        .src_req(src_req)
    );
    always #5 clk_sys = ~clk_sys;
    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : final_report
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            final_report();
        end
    end
    task automatic chk(input reg_word_t got, input reg_word_t exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input reg_addr_t a, input reg_word_t d);
        @(posedge clk_sys);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'h0;
    endtask : wr
    // write then read back in the very next cycle
    task automatic wr_rd(input reg_addr_t a, input reg_word_t d, input reg_word_t exp);
        @(posedge clk_sys);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'h0;
        reg_rd <= 1'h1;
        @(posedge clk_sys);
        reg_rd <= 1'h0;
        #1 chk(reg_rdata_r, exp);
    endtask : wr_rd
    task automatic rd(input reg_addr_t a, input reg_word_t exp);
        @(posedge clk_sys);
        reg_rd <= 1'h1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'h0;
        #1 chk(reg_rdata_r, exp);
    endtask : rd
    // source list settles through the model, then one registered stage
    task automatic arb(input logic v, input int lvl, input int src);
        repeat (4) @(posedge clk_sys);
        #1 chk({15'h0000, irq_valid_r}, {15'h0000, v});
        if (v) begin
            chk({14'h0000, irq_level_r}, 16'(lvl));
            chk({11'h0000, irq_src_r}, 16'(src));
        end
    endtask : arb
    task automatic t_reset;
        for (int a = 0; a < 4; a++) rd(5'(a), 16'h0000);
        $display("reset values done");
    endtask : t_reset
    task automatic t_regs;
        for (int a = 0; a < 6; a++) begin
            wr(5'(a), 16'hFFFF);
            rd(5'(a), mk[a]);
            wr(5'(a), 16'h0000);
        end
        $display("register map done");
    endtask : t_regs
    task automatic t_map;
        for (int f = 0; f < 4; f++) begin
            wr(5'h00, 16'(f << 12));
            raise <= 19'h0_0001;
            arb(f != 0, f, 0);
            wr(5'h00, 16'h0000);
            wr(5'h02, 16'(f << 14));
            raise <= 19'h0_0020;
            arb(f != 0, f - 1, 5);
            wr(5'h02, 16'h0000);
        end
        $display("level codes done");
    endtask : t_map
    task automatic t_tie;
        wr(5'h02, 16'h0001);
        wr(5'h03, 16'h5000);
        raise <= 19'h0_3800;
        arb(1'h1, 0, 11);
        raise <= 19'h0_3000;
        arb(1'h1, 0, 12);
        wr(5'h03, 16'h9000);
        arb(1'h1, 1, 12);
        chk({12'h000, level_hit_r}, 16'h0003);
        chk({11'h000, level_src_r[0]}, 16'h000D);
        chk({11'h000, level_src_r[1]}, 16'h000C);
        wr(5'h03, 16'h0000);
        $display("tie break done");
    endtask : t_tie
    task automatic t_wake;
        low_power <= 1'h1;
        raise <= 19'h0_0400;
        repeat (4) @(posedge clk_sys);
        #1 chk({15'h0000, wake_req_r}, 16'h0000);
        // enabling pin b while asleep must not let it wake the core
        wr(5'h02, 16'h0005);
        repeat (4) @(posedge clk_sys);
        #1 chk({15'h0000, wake_req_r}, 16'h0000);
        raise <= 19'h0_0800;
        repeat (4) @(posedge clk_sys);
        #1 chk({15'h0000, wake_req_r}, 16'h0001);
        @(posedge clk_sys);
        low_power <= 1'h0;
        raise <= '0;
        wr(5'h02, 16'h0000);
        $display("wake done");
    endtask : t_wake
    task automatic t_freeze;
        wr_rd(5'h01, 16'hFF15, 16'h0015);
        @(posedge clk_sys);
        clk_en <= 1'h0;
        wr(5'h01, 16'h002A);
        clk_en <= 1'h1;
        rd(5'h01, 16'h0015);
        wr(5'h01, 16'h0000);
        $display("clock enable done");
    endtask : t_freeze
    initial begin
        repeat (12) @(posedge clk_sys);
        reset_n <= 1'h1;
        t_reset();
        t_regs();
        t_map();
        t_tie();
        t_wake();
        t_freeze();
        final_report();
    end
endmodule : irq_priority_controller_bench
bind irq_priority_controller irq_prio_checker #(.NSRC(NSRC)) chk_i (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_wdata(reg_wdata),
    .reg_rdata_r(reg_rdata_r),
    .src_req(src_req),
    .level_hit_r(level_hit_r),
    .level_src_r(level_src_r),
    .irq_valid_r(irq_valid_r),
    .irq_level_r(irq_level_r),
    .irq_src_r(irq_src_r),
    .low_power(low_power),
    .wake_req_r(wake_req_r)
);

// ---- verif/irq_src_model.sv ----
`timescale 1ns/100ps
module irq_src_model #(
    parameter int NSRC = 19
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // requests ordered by the bench
    input wire logic [NSRC-1:0] raise,
    // level requests toward the controller
    output logic [NSRC-1:0] src_req
);
    logic [NSRC-1:0] src_req_r;
    logic [NSRC-1:0] src_req_nxt;
    assign src_req = src_req_r;
    always_comb begin
        src_req_nxt = raise;
    end
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            src_req_r <= '0;
        end else begin
            src_req_r <= src_req_nxt;
        end
    end
endmodule : irq_src_model
